// ===== irq_pkg.sv
// Constants shared by the interrupt logic
package irq_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PC_W = 13;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_OPTION = 8'h04;
	localparam logic [7:0] OFF_PFLAG = 8'h08;
	localparam logic [7:0] OFF_PENABLE = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	// int_control_reg fields
	localparam int unsigned BIT_GIE = 7;
	localparam int unsigned BIT_PEIE = 6;
	localparam int unsigned BIT_TMR_EN = 5;
	localparam int unsigned BIT_EXT_EN = 4;
	localparam int unsigned BIT_PORT_EN = 3;
	localparam int unsigned BIT_TMR_FLAG = 2;
	localparam int unsigned BIT_EXT_FLAG = 1;
	localparam int unsigned BIT_PORT_FLAG = 0;
	// Option and peripheral fields
	localparam int unsigned BIT_EDGE_SEL = 6;
	localparam int unsigned BIT_COMP = 6;
	// Status fields
	localparam int unsigned BIT_ST_SLEEP = 0;
	localparam int unsigned BIT_ST_PEND = 1;
	localparam int unsigned BIT_ST_BUSY = 2;
	// Reset values
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'hff;
	localparam logic [7:0] RST_PFLAG = 8'h00;
	localparam logic [7:0] RST_PENABLE = 8'h00;
	// Core side
	localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
	// Quarter phase timing: 40 MHz system clock, 50 ns quarter
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned QUARTER_PS = 50000;
	localparam int unsigned QUARTER_CLKS = (QUARTER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned QDIV_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		ST_RUN   = 3'b001,
		ST_WAIT1 = 3'b010,
		ST_WAIT2 = 3'b100
	} take_state_t;
endpackage

// ===== sync_bits.sv
// Two-flop synchroniser with a third stage for change detection
`timescale 1ns/10ps
module sync_bits #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rstn_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_out,
	output logic      [WIDTH-1:0] prev_out
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta <= '0;
			level_out <= '0;
			prev_out <= '0;
		end else begin
			meta <= async_in;
			level_out <= meta;
			prev_out <= level_out;
		end
	end
endmodule

// ===== quarter_gen.sv
// Quarter phase enable generator for the instruction cycle
`timescale 1ns/10ps
module quarter_gen (
	input  wire logic       clk_sys_in,
	input  wire logic       rstn_in,
	output logic      [3:0] phase_out
);
	logic [irq_pkg::QDIV_W-1:0] div;
	logic [1:0]                 quarter;
	logic                       tick;

	assign tick = (div == irq_pkg::QDIV_W'(irq_pkg::QUARTER_CLKS - 1));

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			div <= '0;
			quarter <= 2'h3;
		end else if (tick) begin
			div <= '0;
			quarter <= quarter + 2'h1;
		end else begin
			div <= div + 1'b1;
		end
	end

	// One-cycle pulse at the start of each quarter
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase_out <= 4'h0;
		end else begin
			phase_out <= tick ? (4'h1 << (quarter + 2'h1)) : 4'h0;
		end
	end
endmodule

// ===== mcu_interrupt_logic.sv
// Interrupt logic: flags, enables, vectored request and sleep wake-up
//
// Function
// - Four sources, each with its own flag
// - Global enable bit 7 gates all interrupts
// - Reset clears the global enable
// - Return instruction sets the global enable again
// - Taking clears enable, pushes PC, vectors 0004h
// - Flags set regardless of any enable bit
// - Clearing global enable ignores next cycle, inserts NOP
// - Pin events reach vector in three-four cycles
// - Ext pin edge selectable, sets flag bit 1
// - Ext enable bit 4; wakes from sleep
// - Timer rollover sets flag bit 2, enable 5
// - Upper port change sets flag bit 0
// - Change during port read may be lost
// - Ext flag set in Q4-Q1, sampled Q1
// - Comparator flag and enable in peripheral registers
// - Only the return PC is saved
// - Comparator wake sets peripheral flag bit 6
// - Flag and enable wake sleep without global
`timescale 1ns/10ps
module mcu_interrupt_logic (
	input  wire logic                     clk_sys_in,
	input  wire logic                     rstn_in,
	// AXI4-Lite slave
	input  wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                     s_axi_awvalid_in,
	output logic                          s_axi_awready_out,
	input  wire logic [irq_pkg::DATA_W-1:0] s_axi_wdata_in,
	input  wire logic [3:0]               s_axi_wstrb_in,
	input  wire logic                     s_axi_wvalid_in,
	output logic                          s_axi_wready_out,
	output logic [1:0]                    s_axi_bresp_out,
	output logic                          s_axi_bvalid_out,
	input  wire logic                     s_axi_bready_in,
	input  wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                     s_axi_arvalid_in,
	output logic                          s_axi_arready_out,
	output logic [irq_pkg::DATA_W-1:0]    s_axi_rdata_out,
	output logic [1:0]                    s_axi_rresp_out,
	output logic                          s_axi_rvalid_out,
	input  wire logic                     s_axi_rready_in,
	// Pins and peripherals
	input  wire logic                     ext_int_pin_in,
	input  wire logic [3:0]               port_two_in,
	input  wire logic                     comp_out_in,
	input  wire logic                     timer_rollover_in,
	input  wire logic                     port_read_in,
	// Processor core
	input  wire logic                     return_from_int_instr_in,
	input  wire logic                     sleep_instr_in,
	output logic                          int_request_out,
	output logic                          take_out,
	output logic [irq_pkg::PC_W-1:0]      vector_out,
	output logic                          nop_insert_out,
	output logic                          wake_out,
	output logic                          sleeping_out,
	output logic [3:0]                    phase_out
);
	logic [3:0]                  phase;
	logic                        q1;
	logic                        q2;
	logic                        q4;
	logic                        ext_lvl;
	logic                        ext_prev;
	logic [3:0]                  port_lvl;
	logic                        comp_lvl;
	logic                        comp_prev;
	logic                        global_int_enable;
	logic [3:0]                  enables;
	logic                        timer_overflow_flag;
	logic                        ext_pin_flag;
	logic                        port_change_flag;
	logic [7:0]                  option_reg;
	logic                        comp_flag;
	logic                        comp_enable;
	logic                        ext_pend;
	logic                        ext_edge;
	logic [3:0]                  port_latch;
	logic                        port_primed;
	logic                        port_change;
	logic                        comp_change;
	logic                        any_src;
	logic                        take;
	logic                        sw_gie_clear;
	logic                        guard_pend;
	irq_pkg::take_state_t        state;
	logic                        aw_held;
	logic                        w_held;
	logic [irq_pkg::ADDR_W-1:0]  aw_addr;
	logic [7:0]                  w_byte;
	logic                        w_lane0;
	logic                        do_write;
	logic                        wr_ctrl;
	logic                        wr_option;
	logic                        wr_pflag;
	logic                        wr_penable;
	logic [7:0]                  ctrl_rd;
	logic [7:0]                  rd_byte;
	logic                        rd_hit;
	logic                        wr_hit;

	quarter_gen u_quarter (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.phase_out  (phase)
	);

	sync_bits #(.WIDTH(1)) u_sync_ext (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.async_in   (ext_int_pin_in),
		.level_out  (ext_lvl),
		.prev_out   (ext_prev)
	);

	sync_bits #(.WIDTH(4)) u_sync_port (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.async_in   (port_two_in),
		.level_out  (port_lvl),
		.prev_out   ()
	);

	sync_bits #(.WIDTH(1)) u_sync_comp (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.async_in   (comp_out_in),
		.level_out  (comp_lvl),
		.prev_out   (comp_prev)
	);

	assign q1 = phase[0];
	assign q2 = phase[1];
	assign q4 = phase[3];
	assign phase_out = phase;

	// Source events
	assign ext_edge = option_reg[irq_pkg::BIT_EDGE_SEL] ? (ext_lvl & ~ext_prev) : (~ext_lvl & ext_prev);
	// Compare is suppressed in the read strobe, so such a change may be lost
	assign port_change = port_primed & (port_lvl != port_latch) & ~(port_read_in & q2);
	assign comp_change = comp_lvl ^ comp_prev;

	assign any_src = (ext_pin_flag & enables[1]) | (timer_overflow_flag & enables[2])
		| (port_change_flag & enables[0]) | (enables[3] & comp_flag & comp_enable);
	assign int_request_out = global_int_enable & any_src & ~nop_insert_out;
	assign take = q1 & (state == irq_pkg::ST_WAIT2) & int_request_out;
	assign vector_out = irq_pkg::VECTOR_ADDR;

	// Port reference value, refreshed by each port read during Q2
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			port_latch <= 4'h0;
			port_primed <= 1'b0;
		end else if (!port_primed || (port_read_in && q2)) begin
			port_latch <= port_lvl;
			port_primed <= 1'b1;
		end
	end

	// Edge waits for the Q4-Q1 window before it lands in the flag
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ext_pend <= 1'b0;
		end else if (ext_edge) begin
			ext_pend <= 1'b1;
		end else if (q4 || q1) begin
			ext_pend <= 1'b0;
		end
	end

	// Global enable
	assign sw_gie_clear = wr_ctrl & ~w_byte[irq_pkg::BIT_GIE] & global_int_enable
		& ~take & ~return_from_int_instr_in;
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			global_int_enable <= 1'b0;
		end else if (take) begin
			global_int_enable <= 1'b0;
		end else if (return_from_int_instr_in) begin
			global_int_enable <= 1'b1;
		end else if (wr_ctrl) begin
			global_int_enable <= w_byte[irq_pkg::BIT_GIE];
		end
	end

	// Enables: peie, timer, ext, port, high to low
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			enables <= irq_pkg::RST_CTRL[irq_pkg::BIT_PORT_EN +: 4];
		end else if (wr_ctrl) begin
			enables <= w_byte[irq_pkg::BIT_PORT_EN +: 4];
		end
	end

	// Flags: hardware set beats software clear in the same cycle
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			timer_overflow_flag <= irq_pkg::RST_CTRL[irq_pkg::BIT_TMR_FLAG];
			ext_pin_flag <= irq_pkg::RST_CTRL[irq_pkg::BIT_EXT_FLAG];
			port_change_flag <= irq_pkg::RST_CTRL[irq_pkg::BIT_PORT_FLAG];
		end else begin
			timer_overflow_flag <= (wr_ctrl ? w_byte[irq_pkg::BIT_TMR_FLAG] : timer_overflow_flag)
				| timer_rollover_in;
			ext_pin_flag <= (wr_ctrl ? w_byte[irq_pkg::BIT_EXT_FLAG] : ext_pin_flag)
				| (ext_pend & (q4 | q1));
			port_change_flag <= (wr_ctrl ? w_byte[irq_pkg::BIT_PORT_FLAG] : port_change_flag)
				| port_change;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			option_reg <= irq_pkg::RST_OPTION;
		end else if (wr_option) begin
			option_reg <= w_byte;
		end
	end

	// Comparator flag; a comparator change wakes through it when comp_enable and peie are set
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			comp_flag <= irq_pkg::RST_PFLAG[irq_pkg::BIT_COMP];
			comp_enable <= irq_pkg::RST_PENABLE[irq_pkg::BIT_COMP];
		end else begin
			comp_flag <= (wr_pflag ? w_byte[irq_pkg::BIT_COMP] : comp_flag) | comp_change;
			if (wr_penable) begin
				comp_enable <= w_byte[irq_pkg::BIT_COMP];
			end
		end
	end

	// A software clear of the enable turns the next instruction cycle into a NOP
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			guard_pend <= 1'b0;
			nop_insert_out <= 1'b0;
		end else begin
			if (sw_gie_clear) begin
				guard_pend <= 1'b1;
			end else if (q1) begin
				guard_pend <= 1'b0;
			end
			if (q1) begin
				nop_insert_out <= guard_pend;
			end
		end
	end

	// Request sampled at Q1, two flush cycles, then vector
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= irq_pkg::ST_RUN;
		end else if (!int_request_out) begin
			state <= irq_pkg::ST_RUN;
		end else if (q1) begin
			unique case (state)
				irq_pkg::ST_RUN: begin
					state <= irq_pkg::ST_WAIT1;
				end
				irq_pkg::ST_WAIT1: begin
					state <= irq_pkg::ST_WAIT2;
				end
				irq_pkg::ST_WAIT2: begin
					state <= irq_pkg::ST_RUN;
				end
				default: begin
					state <= irq_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Core pushes only the return PC on this pulse
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			take_out <= 1'b0;
		end else begin
			take_out <= take;
		end
	end

	// Sleep and wake, independent of the global enable
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sleeping_out <= 1'b0;
			wake_out <= 1'b0;
		end else begin
			wake_out <= sleeping_out & any_src;
			if (sleeping_out && any_src) begin
				sleeping_out <= 1'b0;
			end else if (sleep_instr_in) begin
				sleeping_out <= 1'b1;
			end
		end
	end

	// AXI4-Lite write path; address and data taken in either order
	assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
	assign s_axi_wready_out = ~w_held & ~s_axi_bvalid_out;
	assign do_write = aw_held & w_held & ~s_axi_bvalid_out;
	assign wr_hit = (aw_addr == irq_pkg::OFF_CTRL) | (aw_addr == irq_pkg::OFF_OPTION)
		| (aw_addr == irq_pkg::OFF_PFLAG) | (aw_addr == irq_pkg::OFF_PENABLE)
		| (aw_addr == irq_pkg::OFF_STATUS);
	assign wr_ctrl = do_write & w_lane0 & (aw_addr == irq_pkg::OFF_CTRL);
	assign wr_option = do_write & w_lane0 & (aw_addr == irq_pkg::OFF_OPTION);
	assign wr_pflag = do_write & w_lane0 & (aw_addr == irq_pkg::OFF_PFLAG);
	assign wr_penable = do_write & w_lane0 & (aw_addr == irq_pkg::OFF_PENABLE);

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= irq_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata_in[7:0];
				w_lane0 <= s_axi_wstrb_in[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_hit ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// AXI4-Lite read path
	assign s_axi_arready_out = ~s_axi_rvalid_out;
	assign ctrl_rd = {global_int_enable, enables, timer_overflow_flag, ext_pin_flag, port_change_flag};
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		unique case (s_axi_araddr_in)
			irq_pkg::OFF_CTRL: rd_byte = ctrl_rd;
			irq_pkg::OFF_OPTION: rd_byte = option_reg;
			irq_pkg::OFF_PFLAG: rd_byte[irq_pkg::BIT_COMP] = comp_flag;
			irq_pkg::OFF_PENABLE: rd_byte[irq_pkg::BIT_COMP] = comp_enable;
			irq_pkg::OFF_STATUS: begin
				rd_byte[irq_pkg::BIT_ST_SLEEP] = sleeping_out;
				rd_byte[irq_pkg::BIT_ST_PEND] = any_src;
				rd_byte[irq_pkg::BIT_ST_BUSY] = (state != irq_pkg::ST_RUN);
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= '0;
			s_axi_rresp_out <= irq_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= {24'h000000, rd_byte};
			s_axi_rresp_out <= rd_hit ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	gie_take_clear_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		take |=> !global_int_enable && take_out && vector_out == 13'h0004)
		else $error("take did not clear enable and vector");

	gie_return_set_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		return_from_int_instr_in && !take |=> global_int_enable)
		else $error("return did not set global enable");

	req_gated_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		int_request_out == (global_int_enable && !nop_insert_out
		&& ((ctrl_rd[irq_pkg::BIT_EXT_FLAG] && ctrl_rd[irq_pkg::BIT_EXT_EN])
		|| (ctrl_rd[irq_pkg::BIT_TMR_FLAG] && ctrl_rd[irq_pkg::BIT_TMR_EN])
		|| (ctrl_rd[irq_pkg::BIT_PORT_FLAG] && ctrl_rd[irq_pkg::BIT_PORT_EN])
		|| (ctrl_rd[irq_pkg::BIT_PEIE] && comp_flag && comp_enable))))
		else $error("request does not match flags and enables");

	timer_flag_set_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		timer_rollover_in |=> timer_overflow_flag)
		else $error("rollover lost");

	ext_window_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		ext_pend && (q4 || q1) |=> ext_pin_flag)
		else $error("external flag not set in window");

	port_change_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		port_change |=> port_change_flag)
		else $error("port change flag not set");

	sleep_wake_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		sleeping_out && any_src |=> !sleeping_out && wake_out)
		else $error("wake missed");

	nop_guard_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		sw_gie_clear |-> ##[1:9] nop_insert_out)
		else $error("no NOP after enable clear");

	take_latency_a:
	assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		take |-> $past(state == irq_pkg::ST_WAIT2) && !$past(q1))
		else $error("vector taken outside wait sequence");
endmodule

// ===== core_model.sv
// Processor core model: program counter, return stack, sleep and return pulses
`timescale 1ns/10ps
module core_model (
	input  wire logic                     clk_sys_in,
	input  wire logic                     rstn_in,
	input  wire logic                     take_in,
	input  wire logic                     wake_in,
	input  wire logic [irq_pkg::PC_W-1:0] vector_in,
	output logic                          ret_out,
	output logic                          sleep_out,
	output logic      [irq_pkg::PC_W-1:0] pc_out,
	output logic      [3:0]               depth_out
);
	logic [irq_pkg::PC_W-1:0] stack [8];
	initial begin
		ret_out = 1'b0;
		sleep_out = 1'b0;
	end
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pc_out <= 13'h0020;
			depth_out <= 4'h0;
		end else if (take_in) begin
			// Only the program counter is pushed
			stack[depth_out[2:0]] <= pc_out;
			depth_out <= depth_out + 4'h1;
			pc_out <= vector_in;
		end else if (ret_out) begin
			pc_out <= stack[depth_out[2:0] - 3'h1];
			depth_out <= depth_out - 4'h1;
		end else if (wake_in) begin
			pc_out <= pc_out + 13'h0001;
		end
	end
	task automatic do_return;
		@(posedge clk_sys_in);
		ret_out <= 1'b1;
		@(posedge clk_sys_in);
		ret_out <= 1'b0;
	endtask
	task automatic do_sleep;
		@(posedge clk_sys_in);
		sleep_out <= 1'b1;
		@(posedge clk_sys_in);
		sleep_out <= 1'b0;
	endtask
endmodule

// ===== tb.sv
// Self-checking bench for the interrupt logic
`timescale 1ns/10ps
module tb;
	logic                     clk_sys_in = 1'b0;
	logic                     rstn_in = 1'b0;
	logic [7:0]               awaddr = 8'h00;
	logic [7:0]               araddr = 8'h00;
	logic [31:0]              wdata = 32'h0;
	logic                     awvalid = 1'b0;
	logic                     wvalid = 1'b0;
	logic                     bready = 1'b0;
	logic                     arvalid = 1'b0;
	logic                     rready = 1'b0;
	logic                     ext_pin = 1'b0;
	logic [3:0]               pins = 4'h0;
	logic                     comp = 1'b0;
	logic                     roll = 1'b0;
	logic                     port_rd = 1'b0;
	logic [31:0]              rd;
	logic [31:0]              rv;
	logic [1:0]               rsp;
	wire                      awready, wready, bvalid, arready, rvalid;
	wire                      irq, take, nop, wake, sleeping, ret, slp;
	wire  [1:0]               bresp, rresp;
	wire  [31:0]              rdata;
	wire  [irq_pkg::PC_W-1:0] vector, pc;
	wire  [3:0]               phase, depth;
	int                       bad_count = 0;
	int                       total_checks = 0;
	int                       n;
	always #12.5 clk_sys_in = ~clk_sys_in;
	mcu_interrupt_logic dut (
		.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.ext_int_pin_in(ext_pin), .port_two_in(pins), .comp_out_in(comp),
		.timer_rollover_in(roll), .port_read_in(port_rd),
		.return_from_int_instr_in(ret), .sleep_instr_in(slp),
		.int_request_out(irq), .take_out(take), .vector_out(vector), .nop_insert_out(nop),
		.wake_out(wake), .sleeping_out(sleeping), .phase_out(phase)
	);
	core_model core (
		.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .take_in(take), .wake_in(wake),
		.vector_in(vector), .ret_out(ret), .sleep_out(slp), .pc_out(pc), .depth_out(depth)
	);
	function automatic logic [31:0] bv(input int unsigned b);
		return 32'h1 << b;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (bad_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_sys_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_sys_in);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys_in); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys_in); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	// Register reads until the masked value appears, so synchroniser depth is not assumed
	task automatic poll(input logic [7:0] a, input logic [31:0] m);
		n = 0;
		do begin
			rd_reg(a);
			n++;
		end while ((rd & m) !== m && n < 20);
	endtask
	// Sel 0 take, 1 wake, 2 nop; n holds the cycles waited
	task automatic wait_hi(input int sel, input int lim);
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while ((sel == 0 ? take : sel == 1 ? wake : nop) !== 1'b1 && n < lim);
	endtask
	task automatic pulse_roll;
		@(posedge clk_sys_in);
		roll <= 1'b1;
		@(posedge clk_sys_in);
		roll <= 1'b0;
	endtask
	initial begin
		#1000000;
		bad_count++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h3348));
		repeat (8) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		rd_reg(irq_pkg::OFF_CTRL);
		check(rd, 32'(irq_pkg::RST_CTRL));
		rd_reg(irq_pkg::OFF_OPTION);
		check(rd, 32'(irq_pkg::RST_OPTION));
		rd_reg(8'h14);
		check(32'(rsp), 32'(irq_pkg::RESP_SLVERR));
		check(rd, 32'h0);
		// All enables off: every flag must still set
		@(posedge clk_sys_in);
		pins <= 4'($urandom_range(15, 1));
		ext_pin <= 1'b1;
		comp <= 1'b1;
		pulse_roll();
		poll(irq_pkg::OFF_CTRL, 32'h7);
		check(rd & 32'h7, 32'h7);
		poll(irq_pkg::OFF_PFLAG, bv(irq_pkg::BIT_COMP));
		check(rd & bv(irq_pkg::BIT_COMP), bv(irq_pkg::BIT_COMP));
		check(32'(irq), 32'h0);
		// Port read in a Q2 refreshes the change reference
		@(posedge clk_sys_in);
		port_rd <= 1'b1;
		ext_pin <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		port_rd <= 1'b0;
		wr(irq_pkg::OFF_CTRL, 32'h0);
		wr(irq_pkg::OFF_PFLAG, 32'h0);
		rd_reg(irq_pkg::OFF_CTRL);
		check(rd & 32'h7, 32'h0);
		repeat (6) begin
			rv = $urandom;
			wr(irq_pkg::OFF_PENABLE, rv);
			check(32'(rsp), 32'(irq_pkg::RESP_OKAY));
			rd_reg(irq_pkg::OFF_PENABLE);
			check(rd & bv(irq_pkg::BIT_COMP), rv & bv(irq_pkg::BIT_COMP));
		end
		// Timer interrupt taken and returned from
		wr(irq_pkg::OFF_PENABLE, 32'h0);
		wr(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_GIE) | bv(irq_pkg::BIT_TMR_EN));
		pulse_roll();
		wait_hi(0, 60);
		check(32'(take), 32'h1);
		check(32'(vector), 32'(irq_pkg::VECTOR_ADDR));
		repeat (2) @(posedge clk_sys_in);
		check(32'(pc), 32'(irq_pkg::VECTOR_ADDR));
		check(32'(depth), 32'h1);
		rd_reg(irq_pkg::OFF_CTRL);
		check(rd, bv(irq_pkg::BIT_TMR_EN) | bv(irq_pkg::BIT_TMR_FLAG));
		wr(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_TMR_EN));
		core.do_return();
		rd_reg(irq_pkg::OFF_CTRL);
		check(rd, bv(irq_pkg::BIT_GIE) | bv(irq_pkg::BIT_TMR_EN));
		check(32'(pc), 32'h20);
		// Pin edge to vector latency
		wr(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_GIE) | bv(irq_pkg::BIT_EXT_EN));
		@(posedge clk_sys_in);
		ext_pin <= 1'b1;
		wait_hi(0, 60);
		check(32'(n >= 8 && n <= 4 * 4 * irq_pkg::QUARTER_CLKS + 4), 32'h1);
		wr(irq_pkg::OFF_CTRL, 32'h0);
		core.do_return();
		// Falling edge selected: rising must not flag
		wr(irq_pkg::OFF_OPTION, 32'h0);
		wr(irq_pkg::OFF_CTRL, 32'h0);
		@(posedge clk_sys_in);
		ext_pin <= 1'b0;
		poll(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_EXT_FLAG));
		check(rd & bv(irq_pkg::BIT_EXT_FLAG), bv(irq_pkg::BIT_EXT_FLAG));
		wr(irq_pkg::OFF_CTRL, 32'h0);
		@(posedge clk_sys_in);
		ext_pin <= 1'b1;
		repeat (16) @(posedge clk_sys_in);
		rd_reg(irq_pkg::OFF_CTRL);
		check(rd & bv(irq_pkg::BIT_EXT_FLAG), 32'h0);
		// Clearing the global enable gives one no-operation cycle
		wr(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_GIE));
		wr(irq_pkg::OFF_CTRL, 32'h0);
		wait_hi(2, 20);
		n = 0;
		while (nop === 1'b1 && n < 20) begin
			check(32'(irq), 32'h0);
			check(32'($onehot0(phase)), 32'h1);
			@(posedge clk_sys_in);
			n++;
		end
		check(n, 4 * irq_pkg::QUARTER_CLKS);
		wr(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_TMR_EN));
		pulse_roll();
		poll(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_TMR_FLAG));
		check(32'(irq), 32'h0);
		wr(irq_pkg::OFF_CTRL, rd | bv(irq_pkg::BIT_GIE));
		wait_hi(0, 60);
		check(32'(take), 32'h1);
		wr(irq_pkg::OFF_CTRL, 32'h0);
		core.do_return();
		// Wake from sleep with the global enable clear
		wr(irq_pkg::OFF_CTRL, 32'h0);
		wr(irq_pkg::OFF_PFLAG, 32'h0);
		wr(irq_pkg::OFF_PENABLE, bv(irq_pkg::BIT_COMP));
		wr(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_PEIE));
		core.do_sleep();
		@(posedge clk_sys_in);
		check(32'(sleeping), 32'h1);
		rd_reg(irq_pkg::OFF_STATUS);
		check(rd, bv(irq_pkg::BIT_ST_SLEEP));
		comp <= 1'b0;
		wait_hi(1, 40);
		check(32'(wake), 32'h1);
		check(32'(depth), 32'h0);
		rd_reg(irq_pkg::OFF_PFLAG);
		check(rd & bv(irq_pkg::BIT_COMP), bv(irq_pkg::BIT_COMP));
		wr(irq_pkg::OFF_PFLAG, 32'h0);
		wr(irq_pkg::OFF_CTRL, bv(irq_pkg::BIT_EXT_EN));
		core.do_sleep();
		@(posedge clk_sys_in);
		ext_pin <= 1'b0;
		wait_hi(1, 40);
		check(32'(wake), 32'h1);
		rd_reg(irq_pkg::OFF_PFLAG);
		check(rd & bv(irq_pkg::BIT_COMP), 32'h0);
		complete_run();
	end
endmodule
